// *** hdl/wgt_pkg.sv ***
/*
  Constants, register map and types for the windowed guard timer.
  Assumes one clock, the guard tick clock, and a synchronous active-low reset.
*/
// Overview of operation
// - Chip reset is requested when the timer expires without a valid reload and reset enable is set; otherwise the time-out flag is set.
// - In window mode a reload counts only between programmed minimum and maximum times.
// - Optional warning interrupt when the timer reaches a programmed value.
// - Enable is set-only; cleared only by hardware or watchdog reset, or by software once a time-out or bad-feed flag is set.
// - A wrong feed sequence acts at once like a time-out: reset or interrupt.
// - A flag records that the watchdog caused the last reset.
// - The time-out counter is a 24-bit down-timer fed by the prescaled tick.
// - Prescaler divides by 4; time-out is 256 to 2^24 prescaled ticks.
// - All logic runs on the dedicated guard tick clock only.
`default_nettype none
package wgt_pkg;
  localparam int          ADDR_W      = 5;
  localparam int          CNT_W       = 24;
  localparam int          PRESC_DIV   = 4;
  // Register byte offsets
  localparam logic [4:0]  ADDR_MODE   = 5'h00;
  localparam logic [4:0]  ADDR_RELOAD = 5'h04;
  localparam logic [4:0]  ADDR_FEED   = 5'h08;
  localparam logic [4:0]  ADDR_COUNT  = 5'h0c;
  localparam logic [4:0]  ADDR_WARN   = 5'h10;
  localparam logic [4:0]  ADDR_WINDOW = 5'h14;
  localparam logic [4:0]  ADDR_STAT   = 5'h18;
  localparam logic [4:0]  ADDR_MASK   = 5'h1c;
  // Mode register fields
  localparam int          MODE_EN     = 0;
  localparam int          MODE_RSTEN  = 1;
  localparam int          MODE_FLAG   = 2;
  // Status and mask fields
  localparam int          STAT_W      = 3;
  localparam int          STAT_WARN   = 0;
  localparam int          STAT_TOUT   = 1;
  localparam int          STAT_BADF   = 2;
  // Reset values and limits
  localparam logic [23:0] RELOAD_RST  = 24'hffffff;
  localparam logic [23:0] RELOAD_MIN  = 24'h0000ff;
  localparam logic [23:0] WINDOW_RST  = 24'hffffff;
  localparam logic [23:0] WARN_RST    = 24'h000000;
  localparam logic [2:0]  MASK_RST    = 3'h0;
  // Feed keys
  localparam logic [7:0]  FEED_KEY_A  = 8'haa;
  localparam logic [7:0]  FEED_KEY_B  = 8'h55;

  typedef enum logic [0:0] {
    WGT_FD_IDLE = 1'b0,
    WGT_FD_KEY  = 1'b1
  } wgt_feed_type;
endpackage
`default_nettype wire

// *** hdl/wgt_prescaler.sv ***
/*
  Fixed divider giving one-cycle tick enables for the guard timer.
  Assumes the enable input is synchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module wgt_prescaler
  import wgt_pkg::*;
#(
  parameter int DIV = PRESC_DIV
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic en_i,
  output logic      tick_o
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] div_r;
  logic [CW-1:0] div_nxt;
  logic          tick_nxt;

  // Divider restarts on enable so the first tick lands a full period later
  always_comb begin
    div_nxt  = '0;
    tick_nxt = 1'b0;
    if (en_i) begin
      if (div_r == CW'(DIV - 1)) begin
        tick_nxt = 1'b1;
      end else begin
        div_nxt = div_r + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      div_r  <= '0;
      tick_o <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_o <= tick_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_tick_gap;
    tick_o |=> !tick_o [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("Prescaler tick spacing below 4");
endmodule
`default_nettype wire

// *** hdl/wgt_guard_timer.sv ***
/*
  Windowed guard timer: 24-bit down-counter, window check, warning,
  keyed feed, reset request and interrupt, plain register port.
  Assumes clk_i is the dedicated guard tick clock and bus strobes are one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module wgt_guard_timer
  import wgt_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rdata_o,
  output logic                   irq_o,
  output logic                   chip_rst_o
);
  logic              en_r, en_nxt;
  logic              rsten_r, rsten_nxt;
  logic              flag_r, flag_nxt;
  logic [CNT_W-1:0]  reload_r, reload_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [CNT_W-1:0]  warn_r, warn_nxt;
  logic [CNT_W-1:0]  win_r, win_nxt;
  logic [STAT_W-1:0] stat_r, stat_nxt;
  logic [STAT_W-1:0] mask_r, mask_nxt;
  wgt_feed_type      fd_r, fd_nxt;
  logic [31:0]       rdata_nxt;
  logic              irq_nxt;
  logic              rst_nxt;
  logic              tick;
  logic              key_ok;
  logic              key_bad;
  logic              early;
  logic              feed_good;
  logic              tout;
  logic              bad_feed;
  logic              warn_hit;
  logic              fault;
  logic              kill_ok;

  wgt_prescaler #(
    .DIV (PRESC_DIV)
  ) u_presc (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .en_i   (en_r),
    .tick_o (tick)
  );

  // Feed sequencer
  always_comb begin
    fd_nxt  = fd_r;
    key_ok  = 1'b0;
    key_bad = 1'b0;
    if (wr_i) begin
      if (fd_r == WGT_FD_KEY) begin
        fd_nxt = WGT_FD_IDLE;
        // Any write between the two keys breaks the sequence
        if (addr_i == ADDR_FEED && wdata_i[7:0] == FEED_KEY_B) begin
          key_ok = 1'b1;
        end else begin
          key_bad = 1'b1;
        end
      end else if (addr_i == ADDR_FEED) begin
        if (wdata_i[7:0] == FEED_KEY_A) begin
          fd_nxt = WGT_FD_KEY;
        end else begin
          key_bad = 1'b1;
        end
      end
    end
  end

  // Event decode
  always_comb begin
    early     = key_ok && (cnt_r > win_r);
    feed_good = key_ok && !early;
    tout      = en_r && tick && (cnt_r == '0);
    bad_feed  = en_r && (key_bad || early);
    warn_hit  = en_r && tick && (cnt_r == warn_r) && (cnt_r != '0);
    fault     = tout || bad_feed;
    kill_ok   = stat_r[STAT_TOUT] || stat_r[STAT_BADF];
  end

  // Registers, counter and events; events override software clears
  always_comb begin
    en_nxt     = en_r;
    rsten_nxt  = rsten_r;
    flag_nxt   = flag_r;
    reload_nxt = reload_r;
    warn_nxt   = warn_r;
    win_nxt    = win_r;
    mask_nxt   = mask_r;
    stat_nxt   = stat_r;
    rst_nxt    = 1'b0;
    if (wr_i) begin
      case (addr_i)
        ADDR_MODE: begin
          if (wdata_i[MODE_EN]) begin
            en_nxt = 1'b1;
          end else if (kill_ok) begin
            en_nxt = 1'b0;
          end
          rsten_nxt = rsten_r | wdata_i[MODE_RSTEN];
          if (wdata_i[MODE_FLAG]) begin
            flag_nxt = 1'b0;
          end
        end
        ADDR_RELOAD: begin
          // Shortest period is 256 prescaled ticks
          if (wdata_i[CNT_W-1:0] < RELOAD_MIN) begin
            reload_nxt = RELOAD_MIN;
          end else begin
            reload_nxt = wdata_i[CNT_W-1:0];
          end
        end
        ADDR_WARN:   warn_nxt = wdata_i[CNT_W-1:0];
        ADDR_WINDOW: win_nxt  = wdata_i[CNT_W-1:0];
        ADDR_STAT:   stat_nxt = stat_r & ~wdata_i[STAT_W-1:0];
        ADDR_MASK:   mask_nxt = wdata_i[STAT_W-1:0];
        default: begin
        end
      endcase
    end
    if (!en_r || feed_good || fault) begin
      cnt_nxt = reload_r;
    end else if (tick) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end else begin
      cnt_nxt = cnt_r;
    end
    if (warn_hit) begin
      stat_nxt[STAT_WARN] = 1'b1;
    end
    if (fault) begin
      if (rsten_r) begin
        // Watchdog reset returns the block to its disabled state
        rst_nxt   = 1'b1;
        flag_nxt  = 1'b1;
        en_nxt    = 1'b0;
        rsten_nxt = 1'b0;
      end else begin
        stat_nxt[STAT_TOUT] = stat_nxt[STAT_TOUT] | tout;
        stat_nxt[STAT_BADF] = stat_nxt[STAT_BADF] | bad_feed;
      end
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  // Read port
  always_comb begin
    rdata_nxt = '0;
    if (rd_i) begin
      case (addr_i)
        ADDR_MODE:   rdata_nxt = {29'h0, flag_r, rsten_r, en_r};
        ADDR_RELOAD: rdata_nxt = {8'h0, reload_r};
        ADDR_COUNT:  rdata_nxt = {8'h0, cnt_r};
        ADDR_WARN:   rdata_nxt = {8'h0, warn_r};
        ADDR_WINDOW: rdata_nxt = {8'h0, win_r};
        ADDR_STAT:   rdata_nxt = {29'h0, stat_r};
        ADDR_MASK:   rdata_nxt = {29'h0, mask_r};
        default:     rdata_nxt = '0;
      endcase
    end
  end

  // Single clock domain: the guard tick clock
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      en_r       <= 1'b0;
      rsten_r    <= 1'b0;
      flag_r     <= 1'b0;
      reload_r   <= RELOAD_RST;
      cnt_r      <= RELOAD_RST;
      warn_r     <= WARN_RST;
      win_r      <= WINDOW_RST;
      stat_r     <= '0;
      mask_r     <= MASK_RST;
      fd_r       <= WGT_FD_IDLE;
      rdata_o    <= '0;
      irq_o      <= 1'b0;
      chip_rst_o <= 1'b0;
    end else begin
      en_r       <= en_nxt;
      rsten_r    <= rsten_nxt;
      flag_r     <= flag_nxt;
      reload_r   <= reload_nxt;
      cnt_r      <= cnt_nxt;
      warn_r     <= warn_nxt;
      win_r      <= win_nxt;
      stat_r     <= stat_nxt;
      mask_r     <= mask_nxt;
      fd_r       <= fd_nxt;
      rdata_o    <= rdata_nxt;
      irq_o      <= irq_nxt;
      chip_rst_o <= rst_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_timeout_rst;
    en_r && rsten_r && tick && cnt_r == '0 |=> chip_rst_o && flag_r && !en_r;
  endproperty
  a_timeout_rst: assert property (p_timeout_rst) else $error("Expiry gave no reset");

  property p_early_feed;
    en_r && key_ok && cnt_r > win_r
      |=> chip_rst_o || stat_r[STAT_BADF];
  endproperty
  a_early_feed: assert property (p_early_feed) else $error("Early feed not punished");

  property p_good_feed;
    en_r && key_ok && cnt_r <= win_r && !tout |=> cnt_r == $past(reload_r) && !chip_rst_o;
  endproperty
  a_good_feed: assert property (p_good_feed) else $error("Valid feed did not reload");

  property p_warn;
    warn_hit |=> stat_r[STAT_WARN];
  endproperty
  a_warn: assert property (p_warn) else $error("Warning flag not set");

  property p_en_sticky;
    en_r && !kill_ok && !fault |=> en_r;
  endproperty
  a_en_sticky: assert property (p_en_sticky) else $error("Enable dropped without cause");

  property p_bad_key;
    en_r && !rsten_r && key_bad |=> stat_r[STAT_BADF] && !chip_rst_o;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("Bad feed not flagged");

  property p_flag;
    chip_rst_o |-> flag_r && !en_r;
  endproperty
  a_flag: assert property (p_flag) else $error("Reset without cause flag");

  property p_count;
    en_r && tick && cnt_r != '0 && !key_ok && !key_bad
      |=> cnt_r == $past(cnt_r) - CNT_W'(1);
  endproperty
  a_count: assert property (p_count) else $error("Counter did not step down");

  property p_reload_min;
    reload_r >= RELOAD_MIN;
  endproperty
  a_reload_min: assert property (p_reload_min) else $error("Reload below minimum");

  property p_seq;
    fd_r == WGT_FD_KEY && wr_i && addr_i != ADDR_FEED && en_r |=> chip_rst_o || stat_r[STAT_BADF];
  endproperty
  a_seq: assert property (p_seq) else $error("Interrupted feed accepted");

  property p_irq;
    irq_o |-> |(stat_r & mask_r);
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt without unmasked status");

  property p_rdata_idle;
    !rd_i |=> rdata_o == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data not cleared");

  property p_read_count;
    rd_i && addr_i == ADDR_COUNT |=> rdata_o == {8'h0, $past(cnt_r)};
  endproperty
  a_read_count: assert property (p_read_count) else $error("Counter read wrong");

  property p_rst_pulse;
    chip_rst_o |=> !chip_rst_o;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("Reset request too long");

  property p_tout_irq;
    tout && !rsten_r |=> stat_r[STAT_TOUT] && !chip_rst_o;
  endproperty
  a_tout_irq: assert property (p_tout_irq) else $error("Expiry gave no interrupt flag");

  property p_dis_hold;
    !en_r |=> cnt_r == $past(reload_r);
  endproperty
  a_dis_hold: assert property (p_dis_hold) else $error("Idle counter not at reload");

  property p_flag_hold;
    flag_r && !(wr_i && addr_i == ADDR_MODE && wdata_i[MODE_FLAG]) |=> flag_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Cause flag lost");

  property p_en_set;
    wr_i && addr_i == ADDR_MODE && wdata_i[MODE_EN] && !(fault && rsten_r) |=> en_r;
  endproperty
  a_en_set: assert property (p_en_set) else $error("Enable write ignored");

  c_timeout_rst: cover property (en_r && rsten_r && tout);
  c_good_feed:   cover property (en_r && feed_good);
  c_warn_irq:    cover property (stat_r[STAT_WARN] && irq_o);
  c_bad_irq:     cover property (stat_r[STAT_BADF] && irq_o);
  c_early_feed:  cover property (en_r && key_ok && early);
endmodule
`default_nettype wire

// *** verification/wgt_guard_timer_tb.sv ***
/*
  Self-checking bench for the windowed guard timer: bus reads and writes, timeouts, feeds.
  Assumes the timer's own assertions run inside the design files; one 100 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module wgt_guard_timer_tb
  import wgt_pkg::*;
;
  logic              clk;
  logic              rstn;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata;
  logic              wr;
  logic              rd;
  logic [31:0]       rdata;
  logic              irq;
  logic              crst;
  int                n_mismatch;
  int                n_checks;
  logic [31:0]       d;
  int                n;
  logic [23:0]       v;

  wgt_guard_timer dut (
    .clk_i     (clk),
    .rstn_i    (rstn),
    .addr_i    (addr),
    .wdata_i   (wdata),
    .wr_i      (wr),
    .rd_i      (rd),
    .rdata_o   (rdata),
    .irq_o     (irq),
    .chip_rst_o(crst)
  );

  always #5 clk = ~clk;

  function automatic logic [31:0] exp_reload(input logic [23:0] w);
    return {8'h00, (w < RELOAD_MIN) ? RELOAD_MIN : w};
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  // Strobes drop for one edge so a following call never re-drives them in one step
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] w);
    @(posedge clk);
    addr  <= a;
    wdata <= w;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] r);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    r = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] e);
    bus_rd(a, d);
    chk(what, e, d);
  endtask

  // Pulse lasts one cycle and may already stand when called: look before waiting
  task automatic wait_crst(output int c);
    c = 0;
    #1;
    while (crst !== 1'b1 && c < 1100) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(32'hb7b6));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd_chk("mode", ADDR_MODE, 32'h0);
    rd_chk("count", ADDR_COUNT, {8'h00, RELOAD_RST});
    rd_chk("window", ADDR_WINDOW, {8'h00, WINDOW_RST});
    rd_chk("stat", ADDR_STAT, 32'h0);
    rd_chk("unmapped", 5'h02, 32'h0);
    // Random reloads around the lower limit, plus both edges
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 24'h0000fe : (i == 1) ? 24'h0000ff : 24'($urandom % 32'h200);
      bus_wr(ADDR_RELOAD, {8'h00, v});
      rd_chk("reload", ADDR_RELOAD, exp_reload(v));
    end
    bus_wr(ADDR_RELOAD, 32'h0000_00ff);
    bus_wr(ADDR_MODE, 32'h3);
    wait_crst(n);
    chk("timeout span", 32'h1, 32'(n >= 1022 && n <= 1030));
    @(posedge clk);
    #1;
    chk("reset pulse", 32'h0, {31'h0, crst});
    rd_chk("mode after", ADDR_MODE, 32'h4);
    bus_wr(ADDR_MODE, 32'h4);
    rd_chk("flag clr", ADDR_MODE, 32'h0);
    bus_wr(ADDR_MODE, 32'h3);
    bus_wr(ADDR_FEED, 32'h12);
    wait_crst(n);
    chk("bad feed reset", 32'h1, 32'(n <= 3));
    // Interrupt mode from here on
    bus_wr(ADDR_WINDOW, 32'h80);
    bus_wr(ADDR_WARN, 32'hf0);
    bus_wr(ADDR_MODE, 32'h5);
    bus_wr(ADDR_MODE, 32'h0);
    rd_chk("en sticky", ADDR_MODE, 32'h1);
    bus_wr(ADDR_FEED, {24'h0, FEED_KEY_B});
    rd_chk("bad key", ADDR_STAT, 32'h4);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus_wr(ADDR_MASK, 32'h7);
    @(posedge clk);
    #1;
    chk("irq on", 32'h1, {31'h0, irq});
    bus_wr(ADDR_STAT, 32'h7);
    @(posedge clk);
    #1;
    chk("irq off", 32'h0, {31'h0, irq});
    bus_wr(ADDR_FEED, {24'h0, FEED_KEY_A});
    bus_wr(ADDR_MASK, 32'h7);
    rd_chk("split feed", ADDR_STAT, 32'h4);
    bus_wr(ADDR_STAT, 32'h7);
    bus_wr(ADDR_FEED, {24'h0, FEED_KEY_A});
    bus_wr(ADDR_FEED, {24'h0, FEED_KEY_B});
    rd_chk("early feed", ADDR_STAT, 32'h4);
    bus_wr(ADDR_STAT, 32'h7);
    repeat (600) @(posedge clk);
    bus_rd(ADDR_STAT, d);
    chk("warning", 32'h1, {31'h0, d[STAT_WARN]});
    bus_wr(ADDR_STAT, 32'h7);
    bus_wr(ADDR_FEED, {24'h0, FEED_KEY_A});
    bus_wr(ADDR_FEED, {24'h0, FEED_KEY_B});
    bus_rd(ADDR_COUNT, d);
    chk("reloaded", 32'h1, 32'(d >= 32'hfd && d <= 32'hff));
    rd_chk("good feed", ADDR_STAT, 32'h0);
    bus_wr(ADDR_MASK, 32'h2);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (crst !== 1'b0)
        chk("no chip reset", 32'h0, 32'h1);
    end while (irq !== 1'b1 && n < 1100);
    chk("tout irq span", 32'h1, 32'(n >= 1000 && n <= 1040));
    bus_rd(ADDR_STAT, d);
    chk("tout stat", 32'h1, {31'h0, d[STAT_TOUT]});
    bus_wr(ADDR_MODE, 32'h0);
    rd_chk("disable", ADDR_MODE, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
